/* sac_pkg.sv */
// Package for the successive-approximation converter control block.
// Assumes an APB slave with 32-bit data and byte-addressed aligned words.
package sac_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    localparam logic [1:0] IDX_CSR = 2'h0;
    localparam logic [1:0] IDX_RES_HIGH = 2'h1;
    localparam logic [1:0] IDX_RES_LOW = 2'h2;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_W = 12;

    // Control/status field positions
    localparam int CSR_DONE_BIT = 7;
    localparam int CSR_FAST_BIT = 6;
    localparam int CSR_ON_BIT = 5;
    localparam int CSR_RSVD_BIT = 4;
    localparam int CSR_CH_MSB = 3;
    localparam int CSR_CH_LSB = 0;
    localparam logic [7:0] CSR_RESET = 8'h00;

    // Result layout
    localparam int RES_W = 10;
    localparam int CH_W = 4;
    localparam logic [RES_W-1:0] RES_RESET = 10'h000;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int DIV_SLOW = 4;
    localparam int DIV_FAST = 2;
    localparam int SAMPLE_CLKS = 3;
    localparam int WAKE_SETTLE_NS = 20000;
    localparam int WAKE_SETTLE_CYC = (WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Converter sequencer states
    typedef enum logic [1:0] {
        SAC_OFF,
        SAC_SAMPLE,
        SAC_COMPARE
    } sac_state_t;

    // Control/status software fields
    typedef struct packed {
        logic fast_clk;
        logic converter_on;
        logic [CH_W-1:0] channel_select;
    } sac_ctrl_t;

    // Analog front-end controls
    typedef struct packed {
        logic power_on;
        logic sample;
        logic [CH_W-1:0] channel;
        logic [RES_W-1:0] dac_code;
    } sac_afe_t;

endpackage : sac_pkg

/* sac_clkdiv.sv */
// Converter clock tick generator: one-cycle tick every 2 or 4 clocks.
// Assumes the reference clock is the CPU clock.
`timescale 1ns/10ps
`default_nettype none

module sac_clkdiv (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire logic fast_i,
    // Tick
    output logic tick_o
);

    typedef struct packed {
        logic [1:0] cnt;
    } sac_div_state_t;

    sac_div_state_t st;
    sac_div_state_t next_st;
    logic [1:0] last;

    // Terminal count picks divide-by-2 or divide-by-4
    always_comb begin
        last = fast_i ? 2'(sac_pkg::DIV_FAST - 1) : 2'(sac_pkg::DIV_SLOW - 1);
        next_st = st;
        tick_o = run_i && (st.cnt >= last);
        if (!run_i || tick_o) begin
            next_st.cnt = 2'h0;
        end else begin
            next_st.cnt = st.cnt + 2'h1;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule // sac_clkdiv

`default_nettype wire

/* sac_adc_ctrl.sv */
// Control and status logic for a 10-bit successive-approximation converter.
// Assumes an APB master, an external DAC/comparator front end, and low-power
// mode inputs from the system controller.
`timescale 1ns/10ps
`default_nettype none

module sac_adc_ctrl #(
    parameter int SAMPLE_CLKS = sac_pkg::SAMPLE_CLKS,
    parameter int WAKE_SETTLE_CYC = sac_pkg::WAKE_SETTLE_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sac_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Low-power modes
    input wire logic wait_mode_i,
    input wire logic halt_mode_i,
    // Analog front end
    input wire logic comp_above_i,
    output logic afe_power_o,
    output logic afe_sample_o,
    output logic [sac_pkg::CH_W-1:0] afe_channel_o,
    output logic [sac_pkg::RES_W-1:0] afe_dac_code_o,
    // Status
    output logic result_unreliable_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        sac_pkg::sac_ctrl_t ctrl;
        logic done;
        logic [sac_pkg::RES_W-1:0] result;
        sac_pkg::sac_state_t phase;
        logic [sac_pkg::RES_W-1:0] sar;
        logic [sac_pkg::RES_W-1:0] trial;
        logic [7:0] samp_cnt;
        logic [31:0] settle_cnt;
        logic unreliable;
        logic [31:0] rdata;
    } sac_top_state_t;

    sac_top_state_t st;
    sac_top_state_t next_st;

    logic tick;
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic [1:0] idx;
    logic addr_ok;
    logic run;
    logic chan_change;
    logic conv_done;
    logic [sac_pkg::RES_W-1:0] cand;
    logic [7:0] wdat;

    // ------------------------------------------------------------------
    // Converter clock
    // ------------------------------------------------------------------
    sac_clkdiv u_div (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .run_i(run),
        .fast_i(st.ctrl.fast_clk),
        .tick_o(tick)
    );

    // APB decode; zero wait states, unmapped offsets answer with error
    always_comb begin
        idx = paddr[sac_pkg::ADDR_LSB +: 2];
        addr_ok = (paddr[sac_pkg::ADDR_W-1:sac_pkg::ADDR_LSB+2] == '0) &&
                  (paddr[sac_pkg::ADDR_LSB-1:0] == '0) && (idx != 2'h3);
        setup = psel && !penable;
        access = psel && penable;
        wr = access && pwrite && addr_ok;
        rd = access && !pwrite && addr_ok;
        wdat = pwdata[7:0];
    end

    // Handshake and read data outputs
    assign pready = 1'b1;
    assign pslverr = access && !addr_ok;
    assign prdata = st.rdata;

    // Front-end drive
    assign afe_power_o = run;
    assign afe_sample_o = (st.phase == sac_pkg::SAC_SAMPLE);
    assign afe_channel_o = st.ctrl.channel_select;
    assign afe_dac_code_o = st.trial;
    assign result_unreliable_o = st.unreliable;

    // Halt powers the converter down; wait mode has no influence
    assign run = st.ctrl.converter_on && !halt_mode_i;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        chan_change = wr && (idx == sac_pkg::IDX_CSR) &&
                      (wdat[sac_pkg::CSR_CH_MSB:sac_pkg::CSR_CH_LSB] != st.ctrl.channel_select);
        conv_done = 1'b0;
        // Keep the trial bit when the comparator says input is above
        cand = comp_above_i ? st.trial : (st.trial & ~(st.sar));

        // Read data is captured in setup so it is stable in the access phase
        if (setup) begin
            unique case (paddr[sac_pkg::ADDR_LSB +: 2])
                sac_pkg::IDX_CSR: next_st.rdata = {24'h00_0000, st.done, st.ctrl.fast_clk,
                                                   st.ctrl.converter_on, 1'b0,
                                                   st.ctrl.channel_select};
                sac_pkg::IDX_RES_HIGH: next_st.rdata = {24'h00_0000,
                                                        st.result[sac_pkg::RES_W-1:2]};
                sac_pkg::IDX_RES_LOW: next_st.rdata = {30'h0000_0000, st.result[1:0]};
                default: next_st.rdata = sac_pkg::RDATA_ZERO;
            endcase
        end

        // Settle counter after leaving halt
        if (halt_mode_i) begin
            next_st.settle_cnt = 32'(WAKE_SETTLE_CYC);
            next_st.unreliable = 1'b1;
        end else if (st.settle_cnt != 32'h0000_0000) begin
            next_st.settle_cnt = st.settle_cnt - 32'h0000_0001;
        end else begin
            next_st.unreliable = 1'b0;
        end

        // Sequencer; sample and compare steps advance on converter clock ticks, leaving off does not wait for one
        if (!run) begin
            next_st.phase = sac_pkg::SAC_OFF;
            next_st.trial = '0;
        end else begin
            unique case (st.phase)
                sac_pkg::SAC_OFF: begin
                    next_st.phase = sac_pkg::SAC_SAMPLE;
                    next_st.samp_cnt = '0;
                end
                sac_pkg::SAC_SAMPLE: begin
                    if (tick) begin
                        if (st.samp_cnt >= 8'(SAMPLE_CLKS - 1)) begin
                            next_st.phase = sac_pkg::SAC_COMPARE;
                            next_st.sar = 10'h200;
                            next_st.trial = 10'h200;
                        end else begin
                            next_st.samp_cnt = st.samp_cnt + 8'h01;
                        end
                    end
                end
                sac_pkg::SAC_COMPARE: begin
                    if (tick) begin
                        if (st.sar == 10'h001) begin
                            // Full-scale and below-zero inputs saturate naturally
                            conv_done = 1'b1;
                            next_st.result = cand;
                            next_st.phase = sac_pkg::SAC_SAMPLE;
                            next_st.samp_cnt = '0;
                            next_st.trial = '0;
                        end else begin
                            next_st.sar = st.sar >> 1;
                            next_st.trial = cand | (st.sar >> 1);
                        end
                    end
                end
                default: next_st.phase = sac_pkg::SAC_OFF;
            endcase
        end

        // Software writes to control/status
        if (wr && idx == sac_pkg::IDX_CSR) begin
            next_st.ctrl.fast_clk = wdat[sac_pkg::CSR_FAST_BIT];
            next_st.ctrl.converter_on = wdat[sac_pkg::CSR_ON_BIT];
            next_st.ctrl.channel_select = wdat[sac_pkg::CSR_CH_MSB:sac_pkg::CSR_CH_LSB];
        end

        // Channel change aborts and restarts from sampling
        if (chan_change) begin
            next_st.phase = sac_pkg::SAC_OFF;
            next_st.trial = '0;
        end

        // Completion flag: set wins over clear, except a channel change aborts
        if (conv_done && !chan_change) begin
            next_st.done = 1'b1;
        end else if (rd && idx == sac_pkg::IDX_RES_HIGH) begin
            next_st.done = 1'b0;
        end else if (wr && idx == sac_pkg::IDX_CSR) begin
            next_st.done = 1'b0;
        end
        if (conv_done && chan_change) begin
            next_st.result = st.result;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
            st.ctrl <= sac_pkg::sac_ctrl_t'(sac_pkg::CSR_RESET[5:0]);
            st.result <= sac_pkg::RES_RESET;
            st.phase <= sac_pkg::SAC_OFF;
        end else begin
            st <= next_st;
        end
    end

    // No interrupt output exists; completion is polled

endmodule // sac_adc_ctrl

`default_nettype wire

/* sac_afe_model.sv */
// Analog front-end model: sixteen input levels held as ten-bit codes.
// Assumes the bench sets the levels and the converter drives the controls.
`timescale 1ns/10ps
`default_nettype none

module sac_afe_model (
    // Converter side
    input wire logic clk_i,
    input wire logic power_i,
    input wire logic [3:0] chan_i,
    input wire logic [9:0] dac_i,
    // Bench side
    input wire logic [15:0][9:0] lvl_i,
    output logic above_o
);
    logic wob = 1'b0;
    // Unpowered comparator output wanders every cycle
    always @(posedge clk_i) wob <= ~wob;
    // Selected level against trial code; codes clamp at both ends
    assign above_o = power_i ? (lvl_i[chan_i] >= dac_i) : wob;
endmodule // sac_afe_model

`default_nettype wire

/* sac_adc_ctrl_asserts.sv */
// Port checker for the converter control block.
// Assumes it is bound to sac_adc_ctrl.
`timescale 1ns/10ps
`default_nettype none

module sac_adc_ctrl_asserts #(
    parameter int WAKE_SETTLE_CYC = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic halt_mode_i,
    input wire logic afe_power_o,
    input wire logic [3:0] afe_channel_o,
    input wire logic result_unreliable_o
);
    int cnt;
    logic [3:0] wch;
    logic acc;
    logic csw;
    // Access phase decode
    assign wch = pwdata[3:0];
    assign acc = psel && penable;
    assign csw = acc && pwrite && paddr == 12'h000;
    // Cycles since halt was last seen
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) cnt <= WAKE_SETTLE_CYC + 4;
        else if (halt_mode_i) cnt <= 0;
        else if (cnt < WAKE_SETTLE_CYC + 4) cnt <= cnt + 1;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    csr_pad_a: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h0 && !prdata[4])
        else $error("control read shows bits outside its fields");
    low_pad_a: assert property (acc && !pwrite && paddr == 12'h008 |-> prdata[31:2] == 30'h0)
        else $error("low result read shows upper bits");
    bad_addr_a: assert property (acc && !(paddr inside {12'h000, 12'h004, 12'h008}) |-> pslverr)
        else $error("unmapped access without error");
    chan_follow_a: assert property (csw |=> afe_channel_o == $past(wch))
        else $error("channel output does not follow write");
    off_write_a: assert property (csw && !pwdata[5] |=> !afe_power_o)
        else $error("converter stays powered after off write");
    on_write_a: assert property (csw && pwdata[5] && !halt_mode_i |=> afe_power_o || halt_mode_i)
        else $error("converter not powered after on write");
    halt_off_a: assert property (halt_mode_i |-> !afe_power_o)
        else $error("converter powered during halt");
    halt_flag_a: assert property (halt_mode_i |=> result_unreliable_o)
        else $error("halt not flagged unreliable");
    settle_hold_a: assert property (cnt < WAKE_SETTLE_CYC - 1 |-> result_unreliable_o)
        else $error("unreliable flag dropped before settle time");
    settle_end_a: assert property (cnt > WAKE_SETTLE_CYC + 2 |-> !result_unreliable_o)
        else $error("unreliable flag held past settle time");
endmodule // sac_adc_ctrl_asserts

bind sac_adc_ctrl sac_adc_ctrl_asserts #(.WAKE_SETTLE_CYC(WAKE_SETTLE_CYC)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .halt_mode_i(halt_mode_i),
    .afe_power_o(afe_power_o), .afe_channel_o(afe_channel_o), .result_unreliable_o(result_unreliable_o)
);

`default_nettype wire

/* sac_tb.sv */
// Self-checking bench for the converter control block.
// Assumes the front-end model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam int SLOW = (3 + 10) * sac_pkg::DIV_SLOW;
    localparam int FAST = (3 + 10) * sac_pkg::DIV_FAST;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic wm = 1'b0;
    logic hm = 1'b0;
    logic [15:0][9:0] lvl = '0;
    logic [31:0] prdata;
    logic pready, pslverr, above, pwr, smp, unrel, se;
    logic [3:0] ch;
    logic [9:0] dac;
    logic [31:0] rd;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    // Clock and cycle count
    initial forever #2 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) cyc <= cyc + 1;
    sac_adc_ctrl #(.SAMPLE_CLKS(3), .WAKE_SETTLE_CYC(8)) uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wait_mode_i(wm), .halt_mode_i(hm), .comp_above_i(above),
        .afe_power_o(pwr), .afe_sample_o(smp), .afe_channel_o(ch), .afe_dac_code_o(dac),
        .result_unreliable_o(unrel));
    sac_afe_model u_afe (.clk_i(ref_clk_i), .power_i(pwr), .chan_i(ch), .dac_i(dac), .lvl_i(lvl),
        .above_o(above));
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus transfer: setup, then access until ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16) begin errors++; end_of_test(); end
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        do begin
            apb(1'b0, 12'h000, 32'h0);
            k++;
        end while (rd[7] !== 1'b1 && k < 100);
        if (k >= 100) begin errors++; end_of_test(); end
    endtask
    task automatic rd_res(input logic [9:0] v);
        apb(1'b0, 12'h008, 32'h0);
        chk("low_byte", rd, {30'h0, v[1:0]});
        apb(1'b0, 12'h004, 32'h0);
        chk("high_byte", rd, {24'h0, v[9:2]});
    endtask
    task automatic conv(input logic [3:0] c, input logic f, input logic [9:0] v, input int et);
        int t;
        lvl[c] <= v;
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h000, {24'h0, 1'b0, f, 2'b10, c});
        t = cyc;
        wait_done();
        t = cyc - t;
        chk("conv_time", {31'h0, t >= et - 4 && t <= et + 12}, 32'h1);
        rd_res(v);
        apb(1'b0, 12'h000, 32'h0);
        chk("done_after_high", {31'h0, rd[7]}, 32'h0);
    endtask
    task automatic s_reset();
        apb(1'b1, 12'h00C, 32'h0000_00FF);
        chk("bad_addr_err", {31'h0, se}, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk("csr_reset", rd, 32'h0);
        rd_res(10'h000);
    endtask
    task automatic s_conv();
        wm <= 1'b1;
        conv(4'h5, 1'b0, 10'h2B7, SLOW);
        conv(4'hF, 1'b1, 10'h3FF, FAST);
        conv(4'h0, 1'b0, 10'h000, SLOW);
        wm <= 1'b0;
    endtask
    task automatic s_clear_chan();
        wait_done();
        apb(1'b1, 12'h000, 32'h0000_00E0);
        apb(1'b0, 12'h000, 32'h0);
        chk("csr_clear", rd, 32'h0000_0060);
        repeat (10) @(posedge ref_clk_i);
        lvl[9] <= 10'h155;
        apb(1'b1, 12'h000, 32'h0000_0069);
        apb(1'b0, 12'h000, 32'h0);
        chk("csr_chan", rd, 32'h0000_0069);
        wait_done();
        rd_res(10'h155);
    endtask
    task automatic s_over_off();
        wait_done();
        apb(1'b0, 12'h008, 32'h0);
        lvl[9] <= 10'h0AA;
        repeat (40) @(posedge ref_clk_i);
        apb(1'b1, 12'h000, 32'h0000_0069);
        wait_done();
        rd_res(10'h0AA);
        apb(1'b1, 12'h000, 32'h0);
        // Power output follows the register combinationally, so it is already low when the write lands
        @(posedge ref_clk_i);
        chk("power_off", {31'h0, pwr}, 32'h0);
        repeat (80) @(posedge ref_clk_i);
        apb(1'b0, 12'h000, 32'h0);
        chk("no_done_off", rd, 32'h0);
    endtask
    task automatic s_halt();
        apb(1'b1, 12'h000, 32'h0000_0029);
        hm <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        chk("halt_power", {31'h0, pwr}, 32'h0);
        chk("halt_unrel", {31'h0, unrel}, 32'h1);
        hm <= 1'b0;
        repeat (16) @(posedge ref_clk_i);
        chk("settled", {31'h0, unrel}, 32'h0);
        wait_done();
        rd_res(10'h0AA);
        // Eight-bit read: high byte alone also clears the flag
        wait_done();
        apb(1'b0, 12'h004, 32'h0);
        chk("high_only", rd, 32'h0000_002A);
        apb(1'b0, 12'h000, 32'h0);
        chk("done_high_only", {31'h0, rd[7]}, 32'h0);
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        s_reset();
        s_conv();
        s_clear_chan();
        s_over_off();
        s_halt();
        end_of_test();
    end
endmodule // testbench

`default_nettype wire
